// file: src/tlp_top.sv
// Purpose: management-side heater control of a passive loopback module
// Assumes: the two-wire slave hands over byte reads and writes with page and address
// Notes:   nonvolatile storage sits outside; it presents stored values and takes store pulses
`timescale 1ns/100ps
`default_nettype none
module tlp_top
    import tlp_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        clock_en,
    // module control pins
    input  wire logic        module_reset_n,
    input  wire logic        low_power_request_pin,
    // attention pin, open drain
    input  wire logic        attention_out_n_i,
    output var  logic        attention_out_n_o,
    output var  logic        attention_out_n_oe,
    // byte register port from the management slave
    input  wire logic [7:0]  reg_page,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output var  logic [7:0]  reg_rdata,
    // temperature sensor
    input  wire logic [15:0] temperature,
    // nonvolatile store
    input  wire logic        nv_ready,
    input  wire logic [7:0]  nv_power_load,
    input  wire logic [15:0] nv_count_load,
    output var  logic        nv_power_store,
    output var  logic [7:0]  nv_power_data,
    output var  logic        nv_count_store,
    output var  logic [15:0] nv_count_data,
    // heater drives
    output var  logic        heater_pwm,
    output var  logic        heater_spot1,
    output var  logic        heater_spot2
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta; // first stage, read only by rst_sync
    logic rst_sync; // released reset for the rest of the design

    // two-stage release so every flop leaves reset on the same edge
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        tlp_init_t   phase;       // init sequence position
        logic [7:0]  power_byte;  // stored heater power setting
        logic [1:0]  power_mode;  // override and set bits
        logic [15:0] count;       // insertion counter
        logic        attn_level;  // software-set attention level
        logic [7:0]  active;      // setting currently applied to heat
        logic [7:0]  rdata;       // read data register
        logic        power_store; // store pulse for power byte
        logic        count_store; // store pulse for counter
        logic        pwm_out;     // gated pwm drive
        logic        spot1;       // first static spot drive
        logic        spot2;       // second static spot drive
        logic        attn_oe;     // pull attention low
        logic        rst_pin_q;   // last reset pin sample
    } tlp_top_state_t;

    tlp_top_state_t state;      // current state
    tlp_top_state_t next_state; // next state

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic pwm_raw;     // ungated pwm from the slot counter
    logic cut_active;  // over-temperature hold
    logic low_power;   // module in low power mode
    logic running;     // init done and slave out of reset
    logic page_pins;   // access targets page 2 upper bytes
    logic lower_space; // access targets the lower page
    logic reset_rise;  // reset pin just released

    // power mode select; default override clear follows the pin
    always_comb
    begin
        if (state.power_mode[OVERRIDE_BIT])
            low_power = state.power_mode[POWER_SET_BIT];
        else
            low_power = low_power_request_pin;
    end

    // address decode shared by reads and writes
    assign lower_space = (reg_addr < UPPER_BASE);
    assign page_pins   = (reg_addr >= UPPER_BASE) && (reg_page == PAGE_PIN_STATE);
    assign running     = (state.phase == TLP_RUN) && module_reset_n;
    assign reset_rise  = module_reset_n && !state.rst_pin_q;

    // ----------------------------------------------------------------
    // pwm and thermal cut-off
    // ----------------------------------------------------------------
    // duty comes from the applied setting, not the stored byte
    tlp_pwm u_pwm (
        .clock  (clock),
        .rst_n  (rst_sync),
        .enable (clock_en),
        .duty   (state.active[DUTY_MSB:0]),
        .pwm_on (pwm_raw)
    );

    // cut-off watches temperature whenever clock_en is high, even in low power
    tlp_cutoff u_cutoff (
        .clock       (clock),
        .rst_n       (rst_sync),
        .enable      (clock_en),
        .temperature (temperature),
        .cut_active  (cut_active)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state             = state;
        next_state.power_store = 1'b0;
        next_state.count_store = 1'b0;
        next_state.rst_pin_q   = module_reset_n;

        // init sequence: load stored values, then count this insertion
        case (state.phase)
            TLP_INIT_WAIT:
            begin
                // wait for the store to present its contents
                if (nv_ready && module_reset_n)
                begin
                    next_state.power_byte = nv_power_load;
                    next_state.count      = nv_count_load;
                    next_state.phase      = TLP_INIT_COUNT;
                end
            end
            TLP_INIT_COUNT:
            begin
                // one count per pass through init
                next_state.count       = 16'(state.count + 1'b1);
                next_state.count_store = 1'b1;
                next_state.phase       = TLP_RUN;
            end
            TLP_RUN:
            begin
                // nothing to sequence in normal running
                next_state.phase = TLP_RUN;
            end
            default:
            begin
                // unreachable encoding falls back to init
                next_state.phase = TLP_INIT_WAIT;
            end
        endcase

        // module reset pin: slave held, user settings back to default
        if (!module_reset_n)
        begin
            next_state.phase      = TLP_INIT_WAIT;
            next_state.power_mode = POWER_MODE_RST;
            next_state.attn_level = ATTN_RST;
        end
        else if (reset_rise)
        begin
            // a release reruns init so the insertion is counted
            next_state.phase = TLP_INIT_WAIT;
        end

        // register writes, only when the slave is answering
        if (reg_wr && running)
        begin
            if (lower_space && (reg_addr == ADDR_HEATER))
            begin
                next_state.power_byte  = reg_wdata;
                next_state.power_store = 1'b1;
            end
            else if (lower_space && (reg_addr == ADDR_POWER_MODE))
            begin
                next_state.power_mode = reg_wdata[POWER_SET_BIT:OVERRIDE_BIT];
            end
            else if (page_pins && (reg_addr == ADDR_ATTN_PIN))
            begin
                next_state.attn_level = reg_wdata[0];
            end
        end

        // applied setting follows the stored byte only in high power;
        // in low power the last applied value is held, not the new one
        if (!low_power)
            next_state.active = state.power_byte;

        // heater drives; all heat stops in low power and during init
        next_state.pwm_out = pwm_raw && running && !low_power && !cut_active;
        next_state.spot1   = state.active[SPOT1_BIT] && running && !low_power;
        next_state.spot2   = state.active[SPOT2_BIT] && running && !low_power;

        // open drain: enable the driver to pull low
        next_state.attn_oe = !state.attn_level;

        // read data register, one cycle after the strobe
        if (reg_rd)
        begin
            if (!module_reset_n)
                next_state.rdata = READ_HELD;
            else if (lower_space && (reg_addr == ADDR_HEATER))
                next_state.rdata = state.power_byte;
            else if (lower_space && (reg_addr == ADDR_POWER_MODE))
                next_state.rdata = {6'h00, state.power_mode};
            else if (page_pins && (reg_addr == ADDR_CNT_LOW))
                next_state.rdata = state.count[7:0];
            else if (page_pins && (reg_addr == ADDR_CNT_HIGH))
                next_state.rdata = state.count[15:8];
            else if (page_pins && (reg_addr == ADDR_RESET_PIN))
                next_state.rdata = READ_PIN_HIGH;
            else if (page_pins && (reg_addr == ADDR_LOWPWR_PIN))
                next_state.rdata = {7'h00, low_power_request_pin};
            else if (page_pins && (reg_addr == ADDR_ATTN_PIN))
                next_state.rdata = {7'h00, attention_out_n_i};
            else
                next_state.rdata = READ_UNMAPPED;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // everything freezes while the clock enable is low
    always_ff @(posedge clock or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            state            <= '0;
            state.phase      <= TLP_INIT_WAIT;
            state.power_mode <= POWER_MODE_RST;
            state.attn_level <= ATTN_RST;
            state.rst_pin_q  <= 1'b1;
        end
        else if (clock_en)
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // outputs straight from the state register, except the attention data tied low
    // ----------------------------------------------------------------
    assign attention_out_n_o  = 1'b0;
    assign attention_out_n_oe = state.attn_oe;
    assign reg_rdata          = state.rdata;
    assign nv_power_store     = state.power_store;
    assign nv_power_data      = state.power_byte;
    assign nv_count_store     = state.count_store;
    assign nv_count_data      = state.count;
    assign heater_pwm         = state.pwm_out;
    assign heater_spot1       = state.spot1;
    assign heater_spot2       = state.spot2;

endmodule // tlp_top
`default_nettype wire

// file: common/tlp_pkg.sv
// Purpose: shared constants and types for the thermal load pwm control block
// Assumes: byte-wide management register access, page select held by the slave
// Notes:   temperatures are signed 16-bit values in 1/256 degree steps
package tlp_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_POWER_MODE = 8'h5D; // lower page, mode override byte
    localparam logic [7:0] ADDR_HEATER     = 8'h62; // lower page, heater power setting
    localparam logic [7:0] ADDR_CNT_LOW    = 8'h8D; // page 2, insertion count low byte
    localparam logic [7:0] ADDR_CNT_HIGH   = 8'h8E; // page 2, insertion count high byte
    localparam logic [7:0] ADDR_RESET_PIN  = 8'h91; // page 2, reset pin level
    localparam logic [7:0] ADDR_LOWPWR_PIN = 8'h92; // page 2, low power pin level
    localparam logic [7:0] ADDR_ATTN_PIN   = 8'h93; // page 2, attention pin level
    localparam logic [7:0] UPPER_BASE      = 8'h80; // first address of the upper pages
    localparam logic [7:0] PAGE_PIN_STATE  = 8'h02; // page holding counter and pin bytes

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int OVERRIDE_BIT = 0;  // software owns the power mode
    localparam int POWER_SET_BIT = 1; // software low power request
    localparam int DUTY_MSB     = 5;  // duty field is bits 5..0
    localparam int SPOT1_BIT    = 6;  // first static heater spot
    localparam int SPOT2_BIT    = 7;  // second static heater spot
    localparam int DUTY_W       = 6;  // width of the duty field

    // ----------------------------------------------------------------
    // reset and read values
    // ----------------------------------------------------------------
    localparam logic [1:0] POWER_MODE_RST = 2'h0;  // override clear after reset
    localparam logic       ATTN_RST       = 1'b1;  // attention released after reset
    localparam logic [7:0] READ_HELD      = 8'hFF; // slave held in reset
    localparam logic [7:0] READ_PIN_HIGH  = 8'h01; // pin byte when the pin is high
    localparam logic [7:0] READ_UNMAPPED  = 8'h00; // anything not decoded

    // ----------------------------------------------------------------
    // thermal limits
    // ----------------------------------------------------------------
    localparam int CUTOFF_DEG   = 80;  // cut-off temperature in degrees
    localparam int HYST_DEG     = 5;   // drop needed before resuming
    localparam int STEPS_PER_DEG = 256; // sensor counts per degree
    localparam logic signed [15:0] TEMP_CUTOFF = 16'(CUTOFF_DEG * STEPS_PER_DEG);
    localparam logic signed [15:0] TEMP_RESUME = 16'((CUTOFF_DEG - HYST_DEG) * STEPS_PER_DEG);

    // ----------------------------------------------------------------
    // pwm period and init sequence
    // ----------------------------------------------------------------
    localparam int PWM_STEPS = 64; // slots per pwm period

    typedef enum logic [1:0] {
        TLP_INIT_WAIT,  // waiting for stored values
        TLP_INIT_COUNT, // counting this insertion
        TLP_RUN         // normal operation
    } tlp_init_t;

endpackage

// file: src/tlp_pwm.sv
// Purpose: free-running 64-slot pwm for the linear heater
// Assumes: duty changes are taken at any slot
// Notes:   output is registered; duty 0 never turns on
`timescale 1ns/100ps
`default_nettype none
module tlp_pwm
    import tlp_pkg::*;
(
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic                      enable,
    // duty in, pwm out
    input  wire logic [tlp_pkg::DUTY_W-1:0] duty,
    output var  logic                      pwm_on
);

    typedef struct packed {
        logic [DUTY_W-1:0] slot; // position within the period
        logic              on;   // registered pwm level
    } tlp_pwm_state_t;

    tlp_pwm_state_t state;      // current state
    tlp_pwm_state_t next_state; // next state

    // slot counter wraps every 64 slots; on for duty of them
    always_comb
    begin
        next_state      = state;
        next_state.slot = DUTY_W'(state.slot + 1'b1);
        next_state.on   = (state.slot < duty);
    end

    // state register, frozen while enable is low
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            state <= '0;
        else if (enable)
            state <= next_state;
    end

    assign pwm_on = state.on;

endmodule // tlp_pwm
`default_nettype wire

// file: src/tlp_cutoff.sv
// Purpose: over-temperature cut-off with hysteresis
// Assumes: temperature is signed, 1/256 degree per count
// Notes:   trips at the limit, clears only 5 degrees below it
`timescale 1ns/100ps
`default_nettype none
module tlp_cutoff
    import tlp_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        enable,
    // sensor and result
    input  wire logic [15:0] temperature,
    output var  logic        cut_active
);

    typedef struct packed {
        logic cut; // pwm held off for heat
    } tlp_cut_state_t;

    tlp_cut_state_t state;      // current state
    tlp_cut_state_t next_state; // next state

    // trip and release; the gap keeps the heater from chattering
    always_comb
    begin
        next_state = state;
        if (!state.cut && ($signed(temperature) >= TEMP_CUTOFF))
            next_state.cut = 1'b1;
        else if (state.cut && ($signed(temperature) <= TEMP_RESUME))
            next_state.cut = 1'b0;
    end

    // state register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            state <= '0;
        else if (enable)
            state <= next_state;
    end

    assign cut_active = state.cut;

endmodule // tlp_cutoff
`default_nettype wire

// file: verification/tlp_top_sva.sv
// Purpose: port-level checks of the heater control block
// Assumes: bench reads with clock_en low only in the freeze check
// Notes:   bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module tlp_top_sva
    import tlp_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        clock_en,
    // pins
    input wire logic        module_reset_n,
    input wire logic        low_power_request_pin,
    input wire logic        attention_out_n_i,
    input wire logic        attention_out_n_o,
    input wire logic        attention_out_n_oe,
    // register port
    input wire logic [7:0]  reg_page,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // sensor, store, heater
    input wire logic [15:0] temperature,
    input wire logic [15:0] nv_count_load,
    input wire logic        nv_power_store,
    input wire logic [7:0]  nv_power_data,
    input wire logic        nv_count_store,
    input wire logic [15:0] nv_count_data,
    input wire logic        heater_pwm
);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // page-2 read taken with the slave out of reset
    sequence rd_at(a);
        clock_en && reg_rd && module_reset_n && reg_page == PAGE_PIN_STATE && reg_addr == a;
    endsequence
    // at or above the cut-off, with the clock enabled
    sequence hot;
        clock_en && $signed(temperature) >= TEMP_CUTOFF;
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    rst_byte_a: assert property (rd_at(ADDR_RESET_PIN) |=> reg_rdata == READ_PIN_HIGH)
        else $error("reset pin byte wrong");
    held_read_a: assert property ((!module_reset_n)[*3] ##0 (clock_en && reg_rd) |=> reg_rdata == READ_HELD)
        else $error("held slave read wrong");
    lp_byte_a: assert property ($stable(low_power_request_pin)[*3] ##0 rd_at(ADDR_LOWPWR_PIN)
        |=> reg_rdata == {7'h00, $past(low_power_request_pin)})
        else $error("low power pin byte wrong");
    attn_byte_a: assert property ($stable(attention_out_n_i)[*3] ##0 rd_at(ADDR_ATTN_PIN)
        |=> reg_rdata == {7'h00, $past(attention_out_n_i)})
        else $error("attention byte wrong");
    power_read_a: assert property (clock_en && reg_rd && module_reset_n && reg_addr == ADDR_HEATER
        |=> reg_rdata == $past(nv_power_data))
        else $error("power byte read wrong");
    power_store_a: assert property (nv_power_store |-> nv_power_data == $past(reg_wdata)
        && $past(reg_wr) && $past(reg_addr) == ADDR_HEATER)
        else $error("power store wrong");
    count_store_a: assert property (nv_count_store |-> nv_count_data == $past(nv_count_load) + 16'h0001)
        else $error("insertion count wrong");
    hot_pwm_off_a: assert property (hot[*3] |=> !heater_pwm)
        else $error("pwm on at cut-off");
    attn_drive_a: assert property ($rose(attention_out_n_oe) |-> $past(reg_wr, 2)
        && $past(reg_addr, 2) == ADDR_ATTN_PIN && !$past(reg_wdata[0], 2))
        else $error("attention pulled without write");
    od_low_a: assert property (attention_out_n_o == 1'b0)
        else $error("open drain drives high");
endmodule // tlp_top_sva
`default_nettype wire

// file: verification/tlp_nv_model.sv
// Purpose: nonvolatile store beside the block
// Assumes: store pulses last one cycle
// Notes:   contents survive block resets, ready comes late on purpose
`timescale 1ns/100ps
`default_nettype none
module tlp_nv_model #(
    parameter logic [7:0]  POWER_INIT  = 8'h00,   // blank part
    parameter logic [15:0] COUNT_INIT  = 16'h0005, // earlier insertions
    parameter int          READY_DELAY = 20        // slow start of the store
) (
    // clock
    input  wire logic        clock,
    // store side
    input  wire logic        nv_power_store,
    input  wire logic [7:0]  nv_power_data,
    input  wire logic        nv_count_store,
    input  wire logic [15:0] nv_count_data,
    // load side
    output var  logic        nv_ready,
    output var  logic [7:0]  nv_power_load,
    output var  logic [15:0] nv_count_load
);
    int wait_cnt = 0; // cycles since power up
    initial nv_power_load = POWER_INIT;
    initial nv_count_load = COUNT_INIT;
    // no reset input: contents outlive every block reset
    always @(posedge clock)
    begin
        if (wait_cnt < READY_DELAY) wait_cnt <= wait_cnt + 1;
        if (nv_power_store) nv_power_load <= nv_power_data;
        if (nv_count_store) nv_count_load <= nv_count_data;
    end
    assign nv_ready = (wait_cnt >= READY_DELAY);
endmodule // tlp_nv_model
`default_nettype wire

// file: verification/thermal_load_pwm_control_tb_top.sv
// Purpose: self-checking bench of the heater control block
// Assumes: clock_en low only in the freeze check
// Notes:   expectations follow the register map and heater rules
`timescale 1ns/100ps
`default_nettype none
module thermal_load_pwm_control_tb_top;
    import tlp_pkg::*;
    logic clock, arst_n, clock_en, module_reset_n, low_power_request_pin;
    logic attention_out_n_o, attention_out_n_oe, reg_wr, reg_rd;
    logic nv_ready, nv_power_store, nv_count_store, heater_pwm, heater_spot1, heater_spot2;
    logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata, nv_power_load, nv_power_data;
    logic [15:0] temperature, nv_count_load, nv_count_data;
    logic attention_out_n_i;
    logic [7:0] tab [4] = '{8'h00, 8'h60, 8'hBF, 8'hC5}; // duty and spot mixes
    int mismatches, checked, n;
    // pull-up on the attention wire
    assign attention_out_n_i = attention_out_n_oe ? 1'b0 : 1'b1;
    tlp_top dut (.clock(clock), .arst_n(arst_n), .clock_en(clock_en), .module_reset_n(module_reset_n),
        .low_power_request_pin(low_power_request_pin), .attention_out_n_i(attention_out_n_i),
        .attention_out_n_o(attention_out_n_o), .attention_out_n_oe(attention_out_n_oe),
        .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temperature(temperature), .nv_ready(nv_ready),
        .nv_power_load(nv_power_load), .nv_count_load(nv_count_load), .nv_power_store(nv_power_store),
        .nv_power_data(nv_power_data), .nv_count_store(nv_count_store), .nv_count_data(nv_count_data),
        .heater_pwm(heater_pwm), .heater_spot1(heater_spot1), .heater_spot2(heater_spot2));
    tlp_nv_model nv (.clock(clock), .nv_power_store(nv_power_store), .nv_power_data(nv_power_data),
        .nv_count_store(nv_count_store), .nv_count_data(nv_count_data), .nv_ready(nv_ready),
        .nv_power_load(nv_power_load), .nv_count_load(nv_count_load));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        {reg_page, reg_addr, reg_wdata, reg_wr} <= {p, a, d, 1'b1};
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // read data is valid just after the taking edge
    task automatic rdc(input logic [7:0] p, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        {reg_page, reg_addr, reg_rd} <= {p, a, 1'b1};
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // one full 64-slot period counts exactly the duty
    task automatic heat(input logic [7:0] b);
        repeat (5) @(posedge clock);
        n = 0;
        repeat (PWM_STEPS)
        begin
            @(posedge clock);
            #1;
            if (heater_pwm === 1'b1) n++;
        end
        chk(16'(n), {10'h000, b[5:0]});
        chk({heater_spot2, heater_spot1}, b[7:6]);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // about twelve times the expected run length
    initial
    begin
        #100000;
        mismatches++;
        report_and_stop();
    end
    initial
    begin
        {arst_n, reg_wr, reg_rd, reg_page, reg_addr, reg_wdata, low_power_request_pin} = '0;
        {clock_en, module_reset_n} = 2'b11;
        temperature = 16'h1900;
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        repeat (40) @(posedge clock);
        rdc(PAGE_PIN_STATE, ADDR_CNT_LOW, 8'h06);
        rdc(PAGE_PIN_STATE, ADDR_CNT_HIGH, 8'h00);
        rdc(PAGE_PIN_STATE, ADDR_RESET_PIN, READ_PIN_HIGH);
        rdc(PAGE_PIN_STATE, 8'hA0, READ_UNMAPPED);
        $display("register test done");
        foreach (tab[i])
        begin
            wr(8'h00, ADDR_HEATER, tab[i]);
            rdc(8'h00, ADDR_HEATER, tab[i]);
            chk(nv_power_load, tab[i]);
            heat(tab[i]);
        end
        $display("heater test done");
        low_power_request_pin <= 1'b1;
        heat(8'h00);
        rdc(PAGE_PIN_STATE, ADDR_LOWPWR_PIN, 8'h01);
        wr(8'h00, ADDR_HEATER, 8'h60);
        heat(8'h00);
        wr(8'h00, ADDR_POWER_MODE, 8'h01);
        heat(8'h60);
        wr(8'h00, ADDR_POWER_MODE, 8'h00);
        low_power_request_pin <= 1'b0;
        heat(8'h60);
        rdc(PAGE_PIN_STATE, ADDR_LOWPWR_PIN, 8'h00);
        wr(8'h00, ADDR_POWER_MODE, 8'h03);
        heat(8'h00);
        wr(8'h00, ADDR_POWER_MODE, 8'h00);
        $display("power mode test done");
        temperature <= TEMP_CUTOFF;
        heat(8'h40);
        temperature <= TEMP_RESUME + 16'sd1;
        heat(8'h40);
        temperature <= TEMP_RESUME;
        heat(8'h60);
        $display("cut-off test done");
        wr(PAGE_PIN_STATE, ADDR_ATTN_PIN, 8'h00);
        rdc(PAGE_PIN_STATE, ADDR_ATTN_PIN, 8'h00);
        wr(PAGE_PIN_STATE, ADDR_ATTN_PIN, 8'h01);
        rdc(PAGE_PIN_STATE, ADDR_ATTN_PIN, 8'h01);
        $display("attention test done");
        clock_en <= 1'b0;
        rdc(PAGE_PIN_STATE, ADDR_CNT_LOW, 8'h01);
        clock_en <= 1'b1;
        module_reset_n <= 1'b0;
        repeat (4) @(posedge clock);
        rdc(PAGE_PIN_STATE, ADDR_RESET_PIN, READ_HELD);
        module_reset_n <= 1'b1;
        repeat (10) @(posedge clock);
        rdc(PAGE_PIN_STATE, ADDR_CNT_LOW, 8'h07);
        rdc(8'h00, ADDR_HEATER, 8'h60);
        heat(8'h60);
        $display("module reset test done");
        report_and_stop();
    end
endmodule // thermal_load_pwm_control_tb_top
bind tlp_top tlp_top_sva u_sva (.clock(clock), .arst_n(arst_n), .clock_en(clock_en),
    .module_reset_n(module_reset_n), .low_power_request_pin(low_power_request_pin),
    .attention_out_n_i(attention_out_n_i), .attention_out_n_o(attention_out_n_o),
    .attention_out_n_oe(attention_out_n_oe), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .temperature(temperature), .nv_count_load(nv_count_load), .nv_power_store(nv_power_store),
    .nv_power_data(nv_power_data), .nv_count_store(nv_count_store), .nv_count_data(nv_count_data),
    .heater_pwm(heater_pwm));
`default_nettype wire
